// ---- verilog/status_word_pkg.sv ----
// Package: register map, field positions, reset values and timing for status word two
`default_nettype none
package status_word_pkg;
    // Register byte offsets
    localparam logic [4:0] OFF_STATUS     = 5'h00;
    localparam logic [4:0] OFF_CONTROL    = 5'h04;
    localparam logic [4:0] OFF_ALLOW_LVL  = 5'h08;
    localparam logic [4:0] OFF_READY_LVL  = 5'h0C;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK   = 5'h14;
    localparam logic [4:0] OFF_VOLTAGE    = 5'h18;
    // Control register fields
    localparam int CTL_SWITCH_ON_BIT = 0;
    localparam int CTL_CLOSE_EN_BIT  = 1;
    localparam int CTL_PANEL_STOP    = 2;
    localparam int CTL_BREAKER_CFG   = 3;
    localparam int CTL_W             = 4;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    // Interrupt status fields
    localparam int IRQ_INFO_TOG    = 0;
    localparam int IRQ_WARN_TOG    = 1;
    localparam int IRQ_FAULT_TOG   = 2;
    localparam int IRQ_SWITCH_OFF  = 3;
    localparam int IRQ_W           = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // Level registers
    localparam int VOLT_W = 16;
    localparam logic [15:0] ALLOW_LVL_RESET = 16'h0000;
    localparam logic [15:0] READY_LVL_RESET = 16'hFFFF;
    // Status word field positions
    localparam int ST_INFO_TOG   = 0;
    localparam int ST_WARN_TOG   = 1;
    localparam int ST_FAULT_TOG  = 2;
    localparam int ST_PC_ALLOWED = 3;
    localparam int ST_CLOSE_RDY  = 4;
    localparam int ST_PC_DETECT  = 5;
    localparam int ST_PC_RELAY   = 6;
    localparam int ST_CLOSE_CMD  = 7;
    localparam int ST_FEEDBACK   = 8;
    localparam int ST_SWITCH_OFF = 9;
    localparam int ST_PC_READY   = 10;
    localparam int ST_CLOSE_EN   = 11;
    localparam int ST_SWITCH_RDY = 12;
    localparam int ST_FILTER_EN  = 13;
    localparam logic [15:0] STATUS_RESET = 16'h0007;
    // Toggle hold time
    localparam longint CLOCK_HZ    = 50000000;
    localparam longint HOLD_TIME_MS = 1000;
    localparam int HOLD_CYCLES = int'((CLOCK_HZ * HOLD_TIME_MS) / 1000);
endpackage : status_word_pkg
`default_nettype wire

// ---- verilog/event_toggle_if.sv ----
// Interface: one event level between the status word and its toggle timer
`default_nettype none
interface event_toggle_if;
    logic new_event;
    logic already_active;
    logic level;
    logic restarted;
    modport source (output new_event, output already_active, input level, input restarted);
    modport timer  (input new_event, input already_active, output level, output restarted);
endinterface : event_toggle_if
`default_nettype wire

// ---- verilog/input_sync.sv ----
// Two-flop synchroniser for pin-level inputs
`default_nettype none
module input_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("WIDTH must be at least one");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (reset) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : input_sync
`default_nettype wire

// ---- verilog/event_toggle.sv ----
// Timer that pulls an event indication low for the hold time on a repeated event
`default_nettype none
module event_toggle #(
    parameter int HOLD_CYCLES = status_word_pkg::HOLD_CYCLES
) (
    input  wire logic  clock,
    input  wire logic  reset,
    event_toggle_if.timer port
);
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

    logic [CNT_W-1:0] count;
    logic             busy;
    wire              trigger = port.new_event & port.already_active;

    generate
        if (HOLD_CYCLES < 1) begin : g_bad_hold
            $error("HOLD_CYCLES must be at least one");
        end
    endgenerate

    // A repeat event restarts the full hold even while already low
    always_ff @(posedge clock) begin
        if (reset) begin
            busy  <= 1'b0;
            count <= '0;
        end else if (trigger) begin
            busy  <= 1'b1;
            count <= '0;
        end else if (busy) begin
            busy  <= (count != LAST);
            count <= count + CNT_W'(1);
        end
    end

    assign port.level     = ~busy;
    assign port.restarted = trigger;
endmodule : event_toggle
`default_nettype wire

// ---- verilog/converter_status_word_two.sv ----
// Top: application status word two with Avalon-MM registers and interrupt
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`default_nettype none

// Overview of operation
// (R1) Bit 0 low one second on repeat info
// (R2) Bit 1 low one second on repeat warning
// (R3) Bit 2 low one second on repeat fault
// (R4) Bit 3 set when voltage below allowed level
// (R5) Bit 4 set when ready and interlocks met
// (R6) Bit 5 set while voltage rising toward ready
// (R7) Bit 6 mirrors pre-charge relay output
// (R8) Bit 7 mirrors breaker closing relay output
// (R9) Bit 8 shows breaker closed when configured
// (R10) Bit 9 set on any switch-off request
// (R11) Bit 10 set while voltage above ready level
// (R12) Bit 11 set when both close enables asserted
// (R13) Bit 12 set when all start interlocks met
// (R14) Bit 13 set while line filter energized
// (R15) Bits 14, 15 zero; status word read-only
module converter_status_word_two #(
    parameter int HOLD_CYCLES = status_word_pkg::HOLD_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // Pins from the terminal block
    input  wire logic        switch_on_enable_pin,
    input  wire logic        breaker_close_enable_pin,
    input  wire logic        main_breaker_feedback_pin,
    // Same-clock application signals
    input  wire logic        info_new,
    input  wire logic        info_active,
    input  wire logic        warning_new,
    input  wire logic        warning_active,
    input  wire logic        fault_new,
    input  wire logic        fault_active,
    input  wire logic        quick_stop_active,
    input  wire logic [15:0] dc_link_voltage,
    input  wire logic        precharge_relay_out,
    input  wire logic        main_breaker_close_relay_out,
    input  wire logic        filter_energized,
    output logic      [15:0] status_word
);
    localparam int VW = status_word_pkg::VOLT_W;

    // Merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_value,
                                               input logic [31:0] data,
                                               input logic [3:0]  lanes);
        logic [15:0] merged;
        merged       = old_value;
        if (lanes[0]) begin
            merged[7:0] = data[7:0];
        end
        if (lanes[1]) begin
            merged[15:8] = data[15:8];
        end
        return merged;
    endfunction : lane_merge

    // Register state
    logic [status_word_pkg::CTL_W-1:0] control;
    logic [VW-1:0]                     allow_level;
    logic [VW-1:0]                     ready_level;
    logic [status_word_pkg::IRQ_W-1:0] irq_status;
    logic [status_word_pkg::IRQ_W-1:0] irq_mask;
    logic [VW-1:0]                     last_voltage;
    logic                              last_switch_off;
    logic                              ack;
    logic [31:0]                       next_readdata;
    logic [15:0]                       next_status_word;
    logic [status_word_pkg::IRQ_W-1:0] next_irq_status;

    // Synchronised pins
    logic [2:0] pins_sync;
    wire        hw_switch_on_enable  = pins_sync[0];
    wire        hw_close_enable      = pins_sync[1];
    wire        breaker_closed       = pins_sync[2];

    input_sync #(
        .WIDTH    (3)
    ) u_pin_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in ({main_breaker_feedback_pin, breaker_close_enable_pin,
                    switch_on_enable_pin}),
        .sync_out (pins_sync)
    );

    // Event toggle timers, one per event level
    event_toggle_if evt [3] ();
    logic [2:0] toggle_level;
    logic [2:0] toggle_restart;

    assign evt[0].new_event      = info_new;
    assign evt[0].already_active = info_active;
    assign evt[1].new_event      = warning_new;
    assign evt[1].already_active = warning_active;
    assign evt[2].new_event      = fault_new;
    assign evt[2].already_active = fault_active;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_toggle
            event_toggle #(
                .HOLD_CYCLES (HOLD_CYCLES)
            ) u_toggle (
                .clock (clock),
                .reset (reset),
                .port  (evt[i])
            );
            assign toggle_level[i]   = evt[i].level;
            assign toggle_restart[i] = evt[i].restarted;
        end
    endgenerate

    // Bus decode
    wire request    = avs_read | avs_write;
    wire hit_status = (avs_address == status_word_pkg::OFF_STATUS);
    wire hit_ctl    = (avs_address == status_word_pkg::OFF_CONTROL);
    wire hit_allow  = (avs_address == status_word_pkg::OFF_ALLOW_LVL);
    wire hit_ready  = (avs_address == status_word_pkg::OFF_READY_LVL);
    wire hit_irq    = (avs_address == status_word_pkg::OFF_IRQ_STATUS);
    wire hit_mask   = (avs_address == status_word_pkg::OFF_IRQ_MASK);
    wire hit_volt   = (avs_address == status_word_pkg::OFF_VOLTAGE);
    wire write_now  = avs_write & ack;

    // Software controls
    wire fb_switch_on  = control[status_word_pkg::CTL_SWITCH_ON_BIT];
    wire fb_close_en   = control[status_word_pkg::CTL_CLOSE_EN_BIT];
    wire panel_stop    = control[status_word_pkg::CTL_PANEL_STOP];
    wire breaker_cfg   = control[status_word_pkg::CTL_BREAKER_CFG];

    // Voltage comparisons
    wire below_allowed = dc_link_voltage < allow_level;                       // R4
    wire above_ready   = dc_link_voltage > ready_level;                       // R11
    wire rising        = (dc_link_voltage > last_voltage) && !above_ready;    // R6

    // Interlocks
    wire switch_off_req = !hw_switch_on_enable || !fb_switch_on || panel_stop; // R10
    wire close_enabled  = hw_close_enable && fb_close_en;                     // R12
    wire switch_on_ok   = hw_switch_on_enable && fb_switch_on;
    wire start_ok       = switch_on_ok && close_enabled
                          && !quick_stop_active && !fault_active;            // R13
    wire close_ready    = above_ready && close_enabled
                          && !quick_stop_active && !fault_active;            // R5

    // Assemble the status word
    always_comb begin
        next_status_word                               = '0;      // R15
        next_status_word[status_word_pkg::ST_INFO_TOG]   = toggle_level[0]; // R1
        next_status_word[status_word_pkg::ST_WARN_TOG]   = toggle_level[1]; // R2
        next_status_word[status_word_pkg::ST_FAULT_TOG]  = toggle_level[2]; // R3
        next_status_word[status_word_pkg::ST_PC_ALLOWED] = below_allowed;   // R4
        next_status_word[status_word_pkg::ST_CLOSE_RDY]  = close_ready;     // R5
        next_status_word[status_word_pkg::ST_PC_DETECT]  = rising;          // R6
        next_status_word[status_word_pkg::ST_PC_RELAY]   = precharge_relay_out; // R7
        next_status_word[status_word_pkg::ST_CLOSE_CMD]  = main_breaker_close_relay_out; // R8
        next_status_word[status_word_pkg::ST_FEEDBACK]   = breaker_cfg && breaker_closed; // R9
        next_status_word[status_word_pkg::ST_SWITCH_OFF] = switch_off_req;  // R10
        next_status_word[status_word_pkg::ST_PC_READY]   = above_ready;     // R11
        next_status_word[status_word_pkg::ST_CLOSE_EN]   = close_enabled;   // R12
        next_status_word[status_word_pkg::ST_SWITCH_RDY] = start_ok;        // R13
        next_status_word[status_word_pkg::ST_FILTER_EN]  = filter_energized; // R14
    end

    // Interrupt events; a new event wins over a same-cycle clear
    wire [status_word_pkg::IRQ_W-1:0] irq_events = {switch_off_req & ~last_switch_off,
                                                    toggle_restart};
    wire [status_word_pkg::IRQ_W-1:0] irq_clear  =
        (write_now && hit_irq && avs_byteenable[0]) ?
        avs_writedata[status_word_pkg::IRQ_W-1:0] : '0;

    assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

    // Read mux
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (hit_status) begin
            next_readdata[15:0] = status_word;
        end else if (hit_ctl) begin
            next_readdata[status_word_pkg::CTL_W-1:0] = control;
        end else if (hit_allow) begin
            next_readdata[VW-1:0] = allow_level;
        end else if (hit_ready) begin
            next_readdata[VW-1:0] = ready_level;
        end else if (hit_irq) begin
            next_readdata[status_word_pkg::IRQ_W-1:0] = irq_status;
        end else if (hit_mask) begin
            next_readdata[status_word_pkg::IRQ_W-1:0] = irq_mask;
        end else if (hit_volt) begin
            next_readdata[VW-1:0] = dc_link_voltage;
        end
    end

    // One wait cycle, then the answer for one cycle
    assign avs_waitrequest = request & ~ack;

    always_ff @(posedge clock) begin
        if (reset) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack          <= request & ~ack;
            avs_readdata <= (avs_read & ~ack) ? next_readdata : avs_readdata;
        end
    end

    // Writable registers; the status word ignores writes
    always_ff @(posedge clock) begin
        if (reset) begin
            control     <= status_word_pkg::CONTROL_RESET;
            allow_level <= status_word_pkg::ALLOW_LVL_RESET;
            ready_level <= status_word_pkg::READY_LVL_RESET;
            irq_mask    <= status_word_pkg::IRQ_RESET;
        end else if (write_now) begin
            if (hit_ctl && avs_byteenable[0]) begin
                control <= avs_writedata[status_word_pkg::CTL_W-1:0];
            end
            if (hit_allow) begin
                allow_level <= lane_merge(allow_level, avs_writedata, avs_byteenable);
            end
            if (hit_ready) begin
                ready_level <= lane_merge(ready_level, avs_writedata, avs_byteenable);
            end
            if (hit_mask && avs_byteenable[0]) begin
                irq_mask <= avs_writedata[status_word_pkg::IRQ_W-1:0];
            end
        end
    end

    // Status, history and interrupt state
    always_ff @(posedge clock) begin
        if (reset) begin
            status_word     <= status_word_pkg::STATUS_RESET;
            irq_status      <= status_word_pkg::IRQ_RESET;
            last_voltage    <= '0;
            last_switch_off <= 1'b1;    // Idle level, so no false rise after reset
            irq             <= 1'b0;
        end else begin
            status_word     <= next_status_word;   // R15
            irq_status      <= next_irq_status;
            last_voltage    <= dc_link_voltage;
            last_switch_off <= switch_off_req;
            irq             <= |(next_irq_status & irq_mask);
        end
    end
endmodule : converter_status_word_two
`default_nettype wire

// ---- verif/avalon_host.sv ----
// Partner model: Avalon-MM host making single transfers to the status block
`default_nettype none
module avalon_host (
    input  wire logic        clock,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        avs_address = 5'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // Hold the request until waitrequest is seen low, then release it
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        do @(posedge clock); while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clock);
    endtask : xfer
endmodule : avalon_host
`default_nettype wire

// ---- verif/status_word_two_chk.sv ----
// Checker: port-level properties of status word two
`default_nettype none
module status_word_two_chk #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        avs_read,
    input wire logic        avs_waitrequest,
    input wire logic        switch_on_enable_pin,
    input wire logic        breaker_close_enable_pin,
    input wire logic        info_new,
    input wire logic        info_active,
    input wire logic        fault_active,
    input wire logic        quick_stop_active,
    input wire logic        precharge_relay_out,
    input wire logic        main_breaker_close_relay_out,
    input wire logic        filter_energized,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    int low_n;
    // Length of the current low run of the info toggle bit
    always_ff @(posedge clock) begin
        if (reset || status_word[0] || (info_new && info_active)) low_n <= 0;
        else low_n <= low_n + 1;
    end
    a_relay_mirror: assert property (!$past(reset) |->
        status_word[6] == $past(precharge_relay_out)) else $error("relay bit wrong");
    a_close_mirror: assert property (!$past(reset) |->
        status_word[7] == $past(main_breaker_close_relay_out)) else $error("close bit wrong");
    a_filter_mirror: assert property (!$past(reset) |->
        status_word[13] == $past(filter_energized)) else $error("filter bit wrong");
    a_reserved_zero: assert property (status_word[15:14] == 2'h0)
        else $error("reserved bits set");
    a_close_ready: assert property (status_word[4] |->
        status_word[10] && status_word[11]) else $error("close ready without cause");
    a_enable_pin: assert property (status_word[11] |->
        $past(breaker_close_enable_pin, 3)) else $error("close enable without pin");
    a_switch_off: assert property (!$past(reset) && !$past(switch_on_enable_pin, 3) |->
        status_word[9]) else $error("switch off missing");
    a_run_interlock: assert property (!$past(reset) &&
        $past(fault_active || quick_stop_active) |-> !status_word[12])
        else $error("ready to switch on despite stop");
    a_info_drop: assert property (info_new && info_active |->
        ##2 !status_word[0] [*3]) else $error("info toggle not low");
    a_info_hold: assert property (low_n <= HOLD_CYCLES + 1)
        else $error("info toggle low too long");
    a_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer timing wrong");
    c_info: cover property (info_new && info_active);
    c_close: cover property (status_word[4]);
    c_stop: cover property ($rose(status_word[9]));
endmodule : status_word_two_chk
bind converter_status_word_two status_word_two_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (
    .clock, .reset, .avs_read, .avs_waitrequest, .switch_on_enable_pin,
    .breaker_close_enable_pin, .info_new, .info_active, .fault_active, .quick_stop_active,
    .precharge_relay_out, .main_breaker_close_relay_out, .filter_energized, .status_word);
`default_nettype wire

// ---- verif/converter_status_word_two_bench.sv ----
// Testbench: bus, status bit and event toggle scenarios for status word two
`default_nettype none
module converter_status_word_two_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 8;
    localparam logic [15:0] ALLOW = 16'h0100;
    localparam logic [15:0] READY = 16'h0800;
    // Rows: control, pins {on, close, feedback}, stop, fault, relay, close, filter, voltage
    localparam logic [27:0] ROWS [8] = '{
        {4'h0, 3'h0, 5'h05, 16'h0050}, {4'h3, 3'h6, 5'h02, 16'h0900},
        {4'h3, 3'h6, 5'h10, 16'h0900}, {4'h3, 3'h6, 5'h08, 16'h0800},
        {4'h1, 3'h7, 5'h00, 16'h0900}, {4'hB, 3'h7, 5'h00, 16'h0100},
        {4'h7, 3'h6, 5'h10, 16'h00FF}, {4'h3, 3'h2, 5'h00, 16'h0900}};
    logic        clock, reset, irq, qs, rel, cls, fil, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [2:0]  pins, ev_new, ev_act;
    logic [15:0] volt, status_word, w;
    int          fail_count, cmp_count;
    converter_status_word_two #(.HOLD_CYCLES(HOLD)) i_dut (.clock, .reset, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .irq, .switch_on_enable_pin(pins[2]),
        .breaker_close_enable_pin(pins[1]), .main_breaker_feedback_pin(pins[0]),
        .info_new(ev_new[0]), .info_active(ev_act[0]), .warning_new(ev_new[1]),
        .warning_active(ev_act[1]), .fault_new(ev_new[2]), .fault_active(ev_act[2]),
        .quick_stop_active(qs), .dc_link_voltage(volt), .precharge_relay_out(rel),
        .main_breaker_close_relay_out(cls), .filter_energized(fil), .status_word);
    avalon_host i_host (.clock, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable);
    // Expected word for one row with steady inputs and idle toggles
    function automatic logic [15:0] expw(input logic [27:0] r);
        logic on, ce, hi, ok;
        on = r[23] & r[24];
        ce = r[22] & r[25];
        hi = r[15:0] > READY;
        ok = !r[20] & !r[19];
        expw = {2'h0, r[16], on & ce & ok, ce, hi, !on | r[26], r[27] & r[21], r[17], r[18],
            1'h0, hi & ce & ok, r[15:0] < ALLOW, 3'h7};
    endfunction : expw
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(1'h0, a, 32'h0, q);
        chk($sformatf("register %h", a), e, q);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'h1, a, d, q);
    endtask : wr
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // Clock and watchdog
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {reset, qs, rel, cls, fil, pins, ev_new, ev_act, volt} = {1'h1, 29'h0};
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        rd(status_word_pkg::OFF_CONTROL, 32'h0);
        rd(status_word_pkg::OFF_ALLOW_LVL, 32'h0);
        rd(status_word_pkg::OFF_READY_LVL, 32'hFFFF);
        rd(status_word_pkg::OFF_IRQ_MASK, 32'h0);
        rd(5'h1C, 32'h0);
        wr(status_word_pkg::OFF_ALLOW_LVL, ALLOW);
        wr(status_word_pkg::OFF_READY_LVL, READY);
        wr(status_word_pkg::OFF_IRQ_MASK, 32'hF);
        wr(status_word_pkg::OFF_IRQ_STATUS, 32'hF);
        rd(status_word_pkg::OFF_IRQ_STATUS, 32'h0);
        // Each event level: lone event, then event on top of an active one
        for (int l = 0; l < 3; l++) begin
            ev_new[l] <= 1'h1;
            @(posedge clock);
            ev_new[l] <= 1'h0;
            repeat (2) @(posedge clock);
            chk("toggle idle", 1'h1, status_word[l]);
            ev_new[l] <= 1'h1;
            ev_act[l] <= 1'h1;
            @(posedge clock);
            ev_new[l] <= 1'h0;
            repeat (2) @(posedge clock);
            chk("toggle low", 1'h0, status_word[l]);
            chk("irq set", 1'h1, irq);
            rd(status_word_pkg::OFF_IRQ_STATUS, 32'h1 << l);
            wr(status_word_pkg::OFF_IRQ_STATUS, 32'h1 << l);
            repeat (HOLD) @(posedge clock);
            chk("toggle back", 1'h1, status_word[l]);
            chk("irq clear", 1'h0, irq);
            ev_act[l] <= 1'h0;
            @(posedge clock);
        end
        // Table of steady input combinations
        foreach (ROWS[i]) begin
            {pins, qs, ev_act[2], rel, cls, fil, volt} <= ROWS[i][23:0];
            wr(status_word_pkg::OFF_CONTROL, {28'h0, ROWS[i][27:24]});
            repeat (4) @(posedge clock);
            w = expw(ROWS[i]);
            chk($sformatf("row %0d", i), w, status_word);
            rd(status_word_pkg::OFF_STATUS, w);
        end
        wr(status_word_pkg::OFF_STATUS, 32'hFFFF);
        rd(status_word_pkg::OFF_STATUS, w);
        rd(status_word_pkg::OFF_VOLTAGE, 32'h0900);
        rd(status_word_pkg::OFF_IRQ_STATUS, 32'h8);
        chk("irq stop", 1'h1, irq);
        wr(status_word_pkg::OFF_IRQ_MASK, 32'h0);
        @(posedge clock);
        chk("irq masked", 1'h0, irq);
        wr(status_word_pkg::OFF_IRQ_STATUS, 32'h8);
        rd(status_word_pkg::OFF_IRQ_STATUS, 32'h0);
        // Voltage ramp below the ready level, then steady
        volt <= 16'h0200;
        repeat (4) @(posedge clock) volt <= volt + 16'h0010;
        chk("rising", 1'h1, status_word[5]);
        repeat (4) @(posedge clock);
        chk("steady", 1'h0, status_word[5]);
        report_and_stop();
    end
endmodule : converter_status_word_two_bench
`default_nettype wire
